//--- include/cgp_pkg.sv
// Shared constants and types for the current gauge PWM output block
package cgp_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CGP_CLOCK_HZ        = 20_000_000;
	localparam int CGP_INTERVAL_US     = 6000;
	localparam int CGP_INTERVAL_CYCLES = CGP_INTERVAL_US * (CGP_CLOCK_HZ / 1_000_000);
	localparam int CGP_PWM_FREQ_HZ     = 160;
	localparam int CGP_LEVEL_COUNT     = 128;
	localparam int CGP_HALF_STEPS      = 2 * CGP_LEVEL_COUNT;
	// Longest half step that still meets the PWM rate, so rounded down
	localparam int CGP_STEP_CYCLES     = CGP_CLOCK_HZ / (CGP_PWM_FREQ_HZ * CGP_HALF_STEPS);

	// ==========================================================
	// Current scaling
	localparam int CGP_FULL_SCALE_1A_MA  = 1000;
	localparam int CGP_FULL_SCALE_2A_MA  = 2000;
	localparam int CGP_MOD_FULL_SCALE_MA = 2000;
	localparam int CGP_GAIN_NUM          = 22;
	localparam int CGP_GAIN_DEN          = 10;
	localparam int CGP_FRAC_BITS         = 24;

	// ==========================================================
	// Widths and types
	localparam int CGP_COUNT_W = 21;
	localparam int CGP_STEP_W  = 9;

	typedef logic [CGP_COUNT_W-1:0] cgp_count_t;
	typedef logic [CGP_STEP_W-1:0]  cgp_step_t;
	typedef logic [6:0]             cgp_level_t;
	typedef logic [7:0]             cgp_ramp_t;
	typedef logic signed [7:0]      cgp_current_t;

	localparam cgp_level_t   CGP_ZERO_LEVEL   = 7'h40;
	localparam cgp_level_t   CGP_MAX_LEVEL    = 7'h7f;
	localparam cgp_level_t   CGP_MIN_LEVEL    = 7'h00;
	localparam cgp_current_t CGP_CURRENT_HIGH = 8'h3f;
	localparam cgp_current_t CGP_CURRENT_LOW  = 8'hc0;
	localparam cgp_ramp_t    CGP_RAMP_TOP     = 8'hff;

	typedef enum logic [1:0] {
		CGP_SHUTDOWN,
		CGP_SETTLE,
		CGP_RUN
	} cgp_mode_t;

	// Filter result handed over at each interval end
	typedef struct packed {
		logic       valid;
		cgp_count_t ones;
	} cgp_dump_t;

endpackage

//--- core/cgp_density_filter.sv
// Integrate-and-dump filter for the modulator pulse-density stream
`timescale 1ns/100ps
`default_nettype none
module cgp_density_filter #(
	parameter int INTERVAL_CYCLES = cgp_pkg::CGP_INTERVAL_CYCLES
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          rstN,
	// Stream
	input  wire logic          enable,
	input  wire logic          bitIn,
	// Result
	output cgp_pkg::cgp_dump_t dump
);
	import cgp_pkg::*;

	localparam cgp_count_t INTERVAL_LAST  = cgp_count_t'(INTERVAL_CYCLES - 1);
	localparam cgp_count_t INTERVAL_TOTAL = cgp_count_t'(INTERVAL_CYCLES);

	cgp_count_t cycles_r;
	cgp_count_t cycles_nxt;
	cgp_count_t ones_r;
	cgp_count_t ones_nxt;
	cgp_dump_t  dump_r;
	cgp_dump_t  dump_nxt;

	// ==========================================================
	// Accumulate ones over one whole slot, then dump and restart
	always_comb begin
		cycles_nxt = cycles_r;
		ones_nxt   = ones_r;
		dump_nxt   = '0;
		if (!enable) begin
			cycles_nxt = '0;
			ones_nxt   = '0;
		end else if (cycles_r == INTERVAL_LAST) begin
			dump_nxt.valid = 1'b1;
			dump_nxt.ones  = ones_r + cgp_count_t'(bitIn);
			cycles_nxt     = '0;
			ones_nxt       = '0;
		end else begin
			cycles_nxt = cycles_r + cgp_count_t'(1);
			ones_nxt   = ones_r + cgp_count_t'(bitIn);
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			cycles_r <= '0;
			ones_r   <= '0;
			dump_r   <= '0;
		end else begin
			cycles_r <= cycles_nxt;
			ones_r   <= ones_nxt;
			dump_r   <= dump_nxt;
		end
	end

	assign dump = dump_r;

	// ==========================================================
	// Checks
	cgp_count_t sinceDump_r;

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			sinceDump_r <= '0;
		end else if (!enable) begin
			sinceDump_r <= '0;
		end else if (dump_r.valid) begin
			sinceDump_r <= cgp_count_t'(1);
		end else begin
			sinceDump_r <= sinceDump_r + cgp_count_t'(1);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstN);

	chk_dump_spacing: assert property (dump_r.valid |-> sinceDump_r == INTERVAL_TOTAL)
		else $error("filter dump not one slot after the previous one");
	chk_ones_bound: assert property (dump_r.valid |-> dump_r.ones <= INTERVAL_TOTAL)
		else $error("filter count exceeds slot length");
	chk_dump_single: assert property (dump_r.valid |=> !dump_r.valid)
		else $error("filter dump lasted more than one cycle");

endmodule
`default_nettype wire

//--- core/cgp_pwm_output.sv
// Current gauge back end: filtered bitstream to ramp-compared PWM output
`timescale 1ns/100ps
`default_nettype none
module cgp_pwm_output #(
	parameter int INTERVAL_CYCLES = cgp_pkg::CGP_INTERVAL_CYCLES,
	parameter int FULL_SCALE_MA   = cgp_pkg::CGP_FULL_SCALE_1A_MA,
	// Half-step length; shortening it lets a short run see whole PWM periods
	parameter int STEP_CYCLES     = cgp_pkg::CGP_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// Modulator and control
	input  wire logic             bitIn,
	input  wire logic             lowPowerRequest_n,
	// Outputs
	output logic                  pwmOut,
	output cgp_pkg::cgp_current_t measuredCurrent,
	output logic                  sampleValid
);
	import cgp_pkg::*;

	// ==========================================================
	// Constants
	localparam cgp_step_t  STEP_LAST      = cgp_step_t'(STEP_CYCLES - 1);
	localparam cgp_count_t INTERVAL_TOTAL = cgp_count_t'(INTERVAL_CYCLES);
	// Gain per unit density; 64-bit to keep the product of constants exact
	localparam longint GAIN_K_L =
		(longint'(CGP_LEVEL_COUNT) * CGP_GAIN_DEN * CGP_MOD_FULL_SCALE_MA
		* (longint'(1) << CGP_FRAC_BITS))
		/ (longint'(CGP_GAIN_NUM) * INTERVAL_CYCLES * FULL_SCALE_MA);
	// 32 bits: short slots give a gain far beyond 24 bits
	localparam logic signed [31:0] GAIN_K = 32'(GAIN_K_L);

	// ==========================================================
	// Reset release through two flops
	logic rstMeta_r;
	logic rstN;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_r <= 1'b0;
			rstN      <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN      <= rstMeta_r;
		end
	end

	// ==========================================================
	// Filter
	cgp_dump_t dump;

	cgp_density_filter #(
		.INTERVAL_CYCLES (INTERVAL_CYCLES)
	) uFilter (
		.clock  (clock),
		.rstN   (rstN),
		.enable (lowPowerRequest_n),
		.bitIn  (bitIn),
		.dump   (dump)
	);

	// ==========================================================
	// Map slot density to a duty level
	logic signed [22:0] diff;
	logic signed [47:0] prod;
	logic signed [47:0] scaled;
	cgp_current_t       current;
	cgp_level_t         level;

	always_comb begin
		diff   = $signed({1'b0, dump.ones, 1'b0}) - $signed({2'b00, INTERVAL_TOTAL});
		prod   = $signed({{25{diff[22]}}, diff}) * $signed({{16{GAIN_K[31]}}, GAIN_K});
		scaled = prod >>> CGP_FRAC_BITS;
		// Beyond full scale the level saturates instead of wrapping
		if (scaled > 48'sd63) begin
			current = CGP_CURRENT_HIGH;
		end else if (scaled < -48'sd64) begin
			current = CGP_CURRENT_LOW;
		end else begin
			current = scaled[7:0];
		end
		// Offset by half scale: zero current lands on level 64
		level = {~current[6], current[5:0]};
	end

	// ==========================================================
	// Mode and latched duty
	cgp_mode_t    mode_r;
	cgp_mode_t    mode_nxt;
	cgp_level_t   duty_r;
	cgp_level_t   duty_nxt;
	cgp_current_t measured_r;
	cgp_current_t measured_nxt;

	always_comb begin
		mode_nxt     = mode_r;
		duty_nxt     = duty_r;
		measured_nxt = measured_r;
		if (!lowPowerRequest_n) begin
			mode_nxt     = CGP_SHUTDOWN;
			duty_nxt     = CGP_ZERO_LEVEL;
			measured_nxt = '0;
		end else begin
			case (mode_r)
				CGP_SHUTDOWN: begin
					mode_nxt = CGP_SETTLE;
				end
				CGP_SETTLE, CGP_RUN: begin
					// Duty moves only at a slot end, never mid-slot
					if (dump.valid) begin
						mode_nxt     = CGP_RUN;
						duty_nxt     = level;
						measured_nxt = current;
					end
				end
				default: begin
					mode_nxt = CGP_SHUTDOWN;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			mode_r     <= CGP_SHUTDOWN;
			duty_r     <= CGP_ZERO_LEVEL;
			measured_r <= '0;
		end else begin
			mode_r     <= mode_nxt;
			duty_r     <= duty_nxt;
			measured_r <= measured_nxt;
		end
	end

	// ==========================================================
	// Ramp and compare
	cgp_step_t step_r;
	cgp_step_t step_nxt;
	cgp_ramp_t ramp_r;
	cgp_ramp_t ramp_nxt;
	logic      pwm_r;
	logic      pwm_nxt;
	logic      valid_r;
	logic      valid_nxt;

	always_comb begin
		step_nxt  = step_r;
		ramp_nxt  = ramp_r;
		pwm_nxt   = 1'b0;
		valid_nxt = (mode_nxt == CGP_RUN);
		if (!lowPowerRequest_n) begin
			step_nxt = '0;
			ramp_nxt = '0;
		end else begin
			if (step_r == STEP_LAST) begin
				step_nxt = '0;
				ramp_nxt = ramp_r + 8'h01;
			end else begin
				step_nxt = step_r + cgp_step_t'(1);
			end
			// 256 half steps against 2N+1 gives (N + 1/2)/128
			pwm_nxt = (ramp_r < {duty_r, 1'b1});
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			step_r  <= '0;
			ramp_r  <= '0;
			pwm_r   <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			step_r  <= step_nxt;
			ramp_r  <= ramp_nxt;
			pwm_r   <= pwm_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign pwmOut          = pwm_r;
	assign measuredCurrent = measured_r;
	assign sampleValid     = valid_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstN);

	sequence seqRelease;
		!lowPowerRequest_n ##1 lowPowerRequest_n;
	endsequence

	sequence seqSlotEnd;
		lowPowerRequest_n && dump.valid;
	endsequence

	chk_release_zero: assert property (
		seqRelease |-> duty_r == CGP_ZERO_LEVEL ##1 (duty_r == CGP_ZERO_LEVEL && !valid_r))
		else $error("duty not at zero level after shutdown release");
	chk_zero_half: assert property ((seqSlotEnd and diff == 23'sd0)
		|=> duty_r == CGP_ZERO_LEVEL)
		else $error("zero current did not give half duty");
	chk_pos_above: assert property ((seqSlotEnd and diff > 23'sd0)
		|=> duty_r >= CGP_ZERO_LEVEL)
		else $error("positive current gave duty below half");
	chk_neg_below: assert property ((seqSlotEnd and diff < 23'sd0)
		|=> duty_r < CGP_ZERO_LEVEL)
		else $error("negative current gave duty at or above half");
	chk_duty_hold: assert property ((lowPowerRequest_n && !dump.valid)
		|=> $stable(duty_r))
		else $error("duty changed away from a slot boundary");
	chk_ramp_start: assert property ((lowPowerRequest_n && ramp_r == 8'h00)
		|=> pwmOut)
		else $error("output low at ramp start");
	chk_ramp_top: assert property ((ramp_r == CGP_RAMP_TOP) |=> !pwmOut)
		else $error("output high at ramp top");
	chk_ramp_wrap: assert property (
		(lowPowerRequest_n && ramp_r == CGP_RAMP_TOP && step_r == STEP_LAST)
		|=> ramp_r == 8'h00)
		else $error("ramp did not wrap");
	chk_ramp_steady: assert property ((lowPowerRequest_n && step_r != STEP_LAST)
		|=> $stable(ramp_r))
		else $error("ramp moved between half steps");
	chk_shutdown_idle: assert property (!lowPowerRequest_n
		|=> (!pwmOut && ramp_r == 8'h00 && mode_r == CGP_SHUTDOWN))
		else $error("shutdown did not stop output and ramp");

endmodule
`default_nettype wire

//--- verif/cgp_duty_timer.sv
// Controller timer model that measures one high phase of the PWM output
`timescale 1ns/100ps
`default_nettype none
module cgp_duty_timer (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstN,
	// Capture
	input  wire logic        pwmIn,
	output logic      [31:0] highCount,
	output logic             done
);
	// ==========================================================
	// Capture
	logic pwmPrev;
	logic run;

	// High time over the fixed period gives duty, current follows linearly
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			// High in reset: a phase under way at release is not a start
			pwmPrev   <= 1'b1;
			run       <= 1'b0;
			highCount <= 32'h0;
			done      <= 1'b0;
		end else begin
			pwmPrev <= pwmIn;
			if (pwmIn && !pwmPrev && !done && !run) begin
				run       <= 1'b1;
				highCount <= 32'h1;
			end else if (run && pwmIn) begin
				highCount <= highCount + 32'h1;
			end else if (run) begin
				run  <= 1'b0;
				done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/cgp_pwm_output_tb.sv
// Self-checking bench for the current gauge PWM output block
`timescale 1ns/100ps
`default_nettype none
module cgp_pwm_output_tb;
	import cgp_pkg::*;
	localparam int T  = 64;
	localparam int FS = CGP_FULL_SCALE_1A_MA;
	// Short half step so ramp wrap and whole periods fit in the run
	localparam int S  = 8;

	// ==========================================================
	// Signals
	logic         clock = 1'b0;
	logic         reset_n = 1'b0;
	logic         bitIn = 1'b0;
	logic         lowPowerRequest_n = 1'b1;
	logic         pwmOut;
	cgp_current_t measuredCurrent;
	logic         sampleValid;
	logic  [31:0] highCount;
	logic         timerDone;
	logic         timerRst_n = 1'b0;
	int           fails = 0;
	int           cmp_count = 0;
	int           seed = 32'hb307f599;
	int           ph = 0;
	logic   [7:0] expQ[$];
	logic         bits[T];

	initial forever #25 clock = ~clock;

	// Full scale fixed at build, never changed in the run
	cgp_pwm_output #(.INTERVAL_CYCLES(T), .FULL_SCALE_MA(FS), .STEP_CYCLES(S)) i_dut (
		.clock(clock), .reset_n(reset_n), .bitIn(bitIn),
		.lowPowerRequest_n(lowPowerRequest_n), .pwmOut(pwmOut),
		.measuredCurrent(measuredCurrent), .sampleValid(sampleValid));

	cgp_duty_timer i_timer (.clock(clock), .rstN(timerRst_n), .pwmIn(pwmOut),
		.highCount(highCount), .done(timerDone));

	// ==========================================================
	// Checking and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop();
		if (fails == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Gain 128*10*2000 over 22 times slot length and full scale, floored
	function automatic logic [7:0] exp_code(input int k);
		longint gain;
		longint n;
		gain = (longint'(2560000) << 24) / longint'(22 * T * FS);
		n = 64 + ((longint'(2 * k - T) * gain) >>> 24);
		if (n < 0) n = 0;
		if (n > 127) n = 127;
		return 8'(n - 64);
	endfunction

	// ==========================================================
	// Driver: one slot of exactly k ones in shuffled order
	task automatic send_slot(input int k);
		int   j;
		logic t;
		for (int i = 0; i < T; i++) bits[i] = (i < k);
		for (int i = 0; i < T; i++) begin
			j = {$random(seed)} % T;
			t = bits[i];
			bits[i] = bits[j];
			bits[j] = t;
		end
		for (int i = 0; i < T; i++) begin
			bitIn = bits[i];
			@(posedge clock);
			#1;
		end
		expQ.push_back(exp_code(k));
	endtask

	// ==========================================================
	// Monitor: one latched value per slot
	always begin
		@(posedge clock);
		#1;
		if (sampleValid !== 1'b1) begin
			ph = 0;
		end else begin
			if (ph == 0 && expQ.size() > 0) check({24'h0, measuredCurrent}, expQ.pop_front());
			ph = (ph + 1) % T;
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		int ks[8] = '{32, 48, 16, 40, 20, 64, 0, 0};
		repeat (16) @(posedge clock);
		#1;
		reset_n = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check(sampleValid, 32'h0); // Nothing latched yet
		check(measuredCurrent, 32'h0); // Zero code at start
		// Last level random over the whole density range
		ks[7] = {$random(seed)} % (T + 1);
		foreach (ks[i]) send_slot(ks[i]);
		// Timer armed once the steady level is latched, so it sees one clean phase
		send_slot(20);
		timerRst_n = 1'b1;
		while (timerDone !== 1'b1) send_slot(20);
		check((highCount + S / 2) / S,
			32'(2 * ($signed(exp_code(20)) + 64) + 1));
		// Partial slot then shutdown
		bitIn = 1'b1;
		repeat (10) @(posedge clock);
		#1;
		lowPowerRequest_n = 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check(pwmOut, 32'h0); // Output parked low
		check(sampleValid, 32'h0); // Measurement stopped
		check(measuredCurrent, 32'h0); // Cleared
		lowPowerRequest_n = 1'b1;
		send_slot(48);
		check(sampleValid, 32'h0); // Not yet latched
		send_slot(40);
		repeat (T) @(posedge clock);
		#1;
		check(expQ.size(), 32'h0); // Every slot seen
		report_and_stop();
	end

	// Watchdog
	initial begin
		// Several times the few thousand cycles the run needs
		#(20000 * 50);
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
